// [src/acc_trap_pkg.sv]
// Package with register map, field positions and reset values of the accumulator trap control block.
package acc_trap_pkg;
	localparam logic [31:0] CTRL_OFFSET     = 32'h0000_0000;
	localparam logic [31:0] IRQ_STAT_OFFSET = 32'h0000_0004;
	localparam logic [31:0] IRQ_MASK_OFFSET = 32'h0000_0008;
	localparam int          NEST_DIS_BIT    = 15;
	localparam int          OVA_FLAG_BIT    = 14;
	localparam int          OVB_FLAG_BIT    = 13;
	localparam int          COVA_FLAG_BIT   = 12;
	localparam int          COVB_FLAG_BIT   = 11;
	localparam int          OVA_TE_BIT      = 10;
	localparam int          OVB_TE_BIT      = 9;
	localparam logic [15:0] CTRL_IMPL_MASK  = 16'hFFFE;
	localparam logic [15:0] CTRL_RESET      = 16'h0000;
	localparam int          EVT_OVA         = 0;
	localparam int          EVT_OVB         = 1;
	localparam int          EVT_COVA        = 2;
	localparam int          EVT_COVB        = 3;
	localparam logic [3:0]  EVT_RESET       = 4'h0;
	localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
endpackage

// [src/accumulator_trap_control.sv]
// Accumulator overflow trap control register with AHB-Lite slave and interrupt.
// Operation
// - bit 14 records accumulator A overflow trap
// - bit 13 records accumulator B overflow trap
// - bits 12 and 11 record catastrophic overflows
// - overflow traps only while own enable set
// - bits read/write, reset zero, bit0 zero
//
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module accumulator_trap_control
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	input  wire logic        ova_ovf_i,
	input  wire logic        ovb_ovf_i,
	input  wire logic        ova_cat_i,
	input  wire logic        ovb_cat_i,
	output logic             trap_o,
	output logic             nest_disable_o,
	output logic             irq_o
);
	import acc_trap_pkg::*;

	logic [15:0] ctrl_q;
	logic [15:0] ctrl_d;
	logic [3:0]  stat_q;
	logic [3:0]  stat_d;
	logic [3:0]  mask_q;
	logic [3:0]  mask_d;
	logic        wr_q;
	logic [31:0] addr_q;
	logic        rd_req;
	logic        wr_req;
	logic        wr_ctrl;
	logic        wr_stat;
	logic        wr_mask;
	logic [15:0] set_v;
	logic [3:0]  evt_v;
	logic        ova_trap;
	logic        ovb_trap;
	logic        trap_d;
	logic        nest_disable_d;
	logic        irq_d;
	logic [31:0] rdata_d;

	// A transfer is taken in its address phase, when the bus is ready.
	assign rd_req = hready_i & hsel_i & htrans_i[1] & ~hwrite_i;
	assign wr_req = hready_i & hsel_i & htrans_i[1] & hwrite_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_q <= 1'b0;
		end else if (hready_i) begin
			wr_q <= wr_req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_q <= 32'h0000_0000;
		end else if (hready_i) begin
			addr_q <= haddr_i;
		end
	end

	// Write strobes of the data phase, decoded from the captured address.
	always_comb begin
		wr_ctrl = 1'b0;
		wr_stat = 1'b0;
		wr_mask = 1'b0;
		if (wr_q && (addr_q == CTRL_OFFSET)) begin
			wr_ctrl = 1'b1;
		end else if (wr_q && (addr_q == IRQ_STAT_OFFSET)) begin
			wr_stat = 1'b1;
		end else if (wr_q && (addr_q == IRQ_MASK_OFFSET)) begin
			wr_mask = 1'b1;
		end
	end

	// Overflows trap only while their accumulator's enable is set.
	assign ova_trap = (ova_ovf_i | ova_cat_i) & ctrl_q[OVA_TE_BIT];
	assign ovb_trap = (ovb_ovf_i | ovb_cat_i) & ctrl_q[OVB_TE_BIT];
	assign trap_d   = ova_trap | ovb_trap;

	always_comb begin
		set_v = 16'h0000;
		set_v[OVA_FLAG_BIT]  = ova_ovf_i & ctrl_q[OVA_TE_BIT];
		set_v[OVB_FLAG_BIT]  = ovb_ovf_i & ctrl_q[OVB_TE_BIT];
		set_v[COVA_FLAG_BIT] = ova_cat_i & ctrl_q[OVA_TE_BIT];
		set_v[COVB_FLAG_BIT] = ovb_cat_i & ctrl_q[OVB_TE_BIT];
		evt_v = {set_v[COVB_FLAG_BIT], set_v[COVA_FLAG_BIT], set_v[OVB_FLAG_BIT], set_v[OVA_FLAG_BIT]};
	end

	// Hardware setting of a flag wins over a software write in the same cycle.
	always_comb begin
		if (wr_ctrl) begin
			ctrl_d = (hwdata_i[15:0] & CTRL_IMPL_MASK) | set_v;
		end else begin
			ctrl_d = ctrl_q | set_v;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// Status bits are cleared by writing ones; a new event in the same cycle keeps its bit.
	always_comb begin
		if (wr_stat) begin
			stat_d = (stat_q & ~hwdata_i[3:0]) | evt_v;
		end else begin
			stat_d = stat_q | evt_v;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_q <= EVT_RESET;
		end else begin
			stat_q <= stat_d;
		end
	end

	always_comb begin
		if (wr_mask) begin
			mask_d = hwdata_i[3:0];
		end else begin
			mask_d = mask_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_q <= EVT_RESET;
		end else begin
			mask_q <= mask_d;
		end
	end

	assign nest_disable_d = ctrl_q[NEST_DIS_BIT];
	assign irq_d          = |(stat_q & mask_q);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trap_o <= 1'b0;
		end else begin
			trap_o <= trap_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nest_disable_o <= 1'b0;
		end else begin
			nest_disable_o <= nest_disable_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= irq_d;
		end
	end

	// Read data comes from the next register values, so a read whose address phase
	// meets the data phase of a write to the same register already sees the new word.
	always_comb begin
		if (haddr_i == CTRL_OFFSET) begin
			rdata_d = {16'h0000, ctrl_d & CTRL_IMPL_MASK};
		end else if (haddr_i == IRQ_STAT_OFFSET) begin
			rdata_d = {28'h0000000, stat_d};
		end else if (haddr_i == IRQ_MASK_OFFSET) begin
			rdata_d = {28'h0000000, mask_d};
		end else begin
			rdata_d = 32'h0000_0000;
		end
	end

	// Read data is registered in the address phase so it stands in the data phase.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hrdata_o <= 32'h0000_0000;
		end else if (rd_req) begin
			hrdata_o <= rdata_d;
		end
	end

	// The slave never inserts wait states once it is out of reset.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hreadyout_o <= 1'b0;
		end else begin
			hreadyout_o <= 1'b1;
		end
	end

	// Every transfer ends with an OKAY response, unmapped addresses included.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hresp_o <= 1'b0;
		end else begin
			hresp_o <= 1'b0;
		end
	end
endmodule

// [test/acc_trap_checker.sv]
// Port checker for the accumulator trap control block.
`timescale 1ns/1ps
module acc_trap_checker (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic [31:0] hwdata_i,
	input wire logic [31:0] hrdata_o,
	input wire logic        hreadyout_o,
	input wire logic        hresp_o,
	input wire logic        nest_disable_o,
	input wire logic        ova_ovf_i,
	input wire logic        ovb_ovf_i,
	input wire logic        ova_cat_i,
	input wire logic        ovb_cat_i,
	input wire logic        trap_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	nest_rise_a: assert property ($rose(nest_disable_o) |-> $past(hwdata_i[15], 2)) else $error("nest rise");
	nest_fall_a: assert property ($fell(nest_disable_o) |-> !$past(hwdata_i[15], 2)) else $error("nest fall");
	ready_up_a: assert property (!$past(rst_i) |-> hreadyout_o) else $error("ready");
	trap_cause_a: assert property (!(ova_ovf_i | ovb_ovf_i | ova_cat_i | ovb_cat_i) |=> !trap_o) else $error("trap");
	ready_stay_a: assert property (hreadyout_o |=> hreadyout_o[*3]) else $error("stall");
	rdata_hi_a: assert property (hrdata_o[31:16] == 16'h0000) else $error("rdata");
	resp_ok_a: assert property (!hresp_o) else $error("resp");
endmodule
bind accumulator_trap_control acc_trap_checker i_chk (.clk_i, .rst_i, .hwdata_i, .hrdata_o, .hreadyout_o, .hresp_o,
	.nest_disable_o, .ova_ovf_i, .ovb_ovf_i, .ova_cat_i, .ovb_cat_i, .trap_o);

// [test/tb_accumulator_trap_control.sv]
// Bench for the accumulator trap control block.
`timescale 1ns/1ps
module tb_accumulator_trap_control;
	import acc_trap_pkg::*;
	logic clk_i = 0, rst_i = 1, wr_q = 0, trap, nest, irq, rdy, resp;
	logic [1:0] tr = 0;
	logic [3:0] ev = 0;
	logic [31:0] ad = 0, wd = 0, rdat;
	int error_cnt = 0, num_checks = 0;
	always #2.5 clk_i = ~clk_i;
	accumulator_trap_control i_dut (.clk_i, .rst_i, .hsel_i(1'b1), .haddr_i(ad), .htrans_i(tr), .hwrite_i(wr_q),
		.hsize_i(3'h2), .hwdata_i(wd), .hready_i(rdy), .hrdata_o(rdat), .hreadyout_o(rdy), .hresp_o(resp),
		.ova_ovf_i(ev[0]), .ovb_ovf_i(ev[1]), .ova_cat_i(ev[2]), .ovb_cat_i(ev[3]), .trap_o(trap),
		.nest_disable_o(nest), .irq_o(irq));
	task print_verdict;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected at %0t: %h not %h", $time, s, e);
		end
	endtask
	task wt;
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (rdy !== 1'b1 && n < 50);
		if (n >= 50) begin
			error_cnt++;
			print_verdict;
		end
	endtask
	task xf(input logic [31:0] a, d, e, input logic w);
		tr <= HTRANS_NONSEQ;
		ad <= a;
		wr_q <= w;
		wt;
		tr <= 2'h0;
		wd <= d;
		wt;
		if (!w)
			chk(rdat, e);
	endtask
	task pulse(input logic [3:0] v, input logic t);
		ev <= v;
		@(posedge clk_i);
		ev <= 4'h0;
		#1 chk(trap, t);
		@(posedge clk_i);
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		wt;
		xf(CTRL_OFFSET, 0, 0, 0);
		xf(32'h0000_0010, 0, 0, 0);
		xf(CTRL_OFFSET, 32'h0000_FFFF, 0, 1);
		xf(CTRL_OFFSET, 0, {16'h0000, CTRL_IMPL_MASK}, 0);
		chk(nest, 1);
		xf(CTRL_OFFSET, 0, 0, 1);
		xf(CTRL_OFFSET, 0, 0, 0);
		chk(nest, 0);
		pulse(4'hF, 0);
		xf(CTRL_OFFSET, 32'h0000_0400, 0, 1);
		pulse(4'h1, 1);
		pulse(4'h2, 0);
		xf(CTRL_OFFSET, 0, 32'h0000_4400, 0);
		xf(CTRL_OFFSET, 32'h0000_0200, 0, 1);
		pulse(4'h2, 1);
		xf(CTRL_OFFSET, 0, 32'h0000_2200, 0);
		xf(CTRL_OFFSET, 32'h0000_0600, 0, 1);
		pulse(4'h4, 1);
		pulse(4'h8, 1);
		xf(CTRL_OFFSET, 0, 32'h0000_1E00, 0);
		xf(IRQ_STAT_OFFSET, 0, 32'h0000_000F, 0);
		chk(irq, 0);
		xf(IRQ_MASK_OFFSET, 32'h0000_0002, 0, 1);
		xf(IRQ_MASK_OFFSET, 0, 32'h0000_0002, 0);
		chk(irq, 1);
		xf(IRQ_STAT_OFFSET, 32'h0000_0002, 0, 1);
		xf(IRQ_STAT_OFFSET, 0, 32'h0000_000D, 0);
		chk(irq, 0);
		print_verdict;
	end
endmodule
